/* File: logic/lps_params.svh */
`ifndef LPS_PARAMS_SVH
`define LPS_PARAMS_SVH
// APB register byte offsets
`define LPS_OFF_CMD      12'h000
`define LPS_OFF_STATUS   12'h004
`define LPS_OFF_CONTRAST 12'h008
`define LPS_OFF_MODE     12'h00C
// Command codes
`define LPS_CMD_DISP_OFF   8'hAE
`define LPS_CMD_DISP_ON    8'hAF
`define LPS_CMD_ALL_OFF    8'hA4
`define LPS_CMD_ALL_ON     8'hA5
`define LPS_CMD_NORM       8'hA6
`define LPS_CMD_INV        8'hA7
`define LPS_CMD_DUTYX_CLR  8'hAA
`define LPS_CMD_DUTYX_SET  8'hAB
`define LPS_CMD_SUPPLY_ON  8'h25
`define LPS_CMD_SUPPLY_OFF 8'h24
`define LPS_CMD_SUPPLY_END 8'hED
`define LPS_CMD_RESET      8'hE2
// Output status command: upper nibble 1100
`define LPS_OST_TAG        4'hC
// Contrast command: upper bits 10
`define LPS_VOL_TAG        2'h2
// Reset values
`define LPS_RST_CONTRAST   5'h00
`define LPS_RST_OST        4'h0
// Status bit positions
`define LPS_ST_SAVE        0
`define LPS_ST_DISP_ON     1
`define LPS_ST_ALL_ON      2
`define LPS_ST_SUP_ON      3
`define LPS_ST_SUP_WAIT    4
`define LPS_ST_OSC_RUN     5
`define LPS_ST_DUTYX       6
`define LPS_ST_INV         7
`endif

/* File: logic/lps_pkg.sv */
package lps_pkg;
    // Built-in supply state
    typedef enum logic [1:0] {
        LPS_SUP_OFF,
        LPS_SUP_WAIT,
        LPS_SUP_ON
    } lps_supply_t;
endpackage

/* File: logic/lps_sequencer.sv */
//==========================================================
// Behaviour
// - All-on while display off enters power save
// - Power save stops oscillator and supply
// - Power save drives outputs to positive level
// - Power save ignores clock, floats osc pin
// - Memory and modes kept across power save
// - Display-on or all-off leaves power save
// - Supply-on paired with startup-complete
// - Other commands accepted during startup wait
// - Contrast command loads level, upper bits 100
// - All-points bit lights every segment outside power save
`timescale 1ns/1ps
`include "lps_params.svh"
module lps_sequencer (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        hard_reset_pin,
    input  wire logic        ext_clock_in,
    output logic             oscillator_output_pin_o,
    output logic             oscillator_output_pin_oe,
    // Analog and driver controls
    output logic             osc_enable,
    output logic             supply_enable,
    output logic             supply_static_current,
    output logic             driver_enable,
    output logic             outputs_to_vdd,
    output logic             all_points_lit,
    output logic             display_inverse,
    output logic [4:0]       lcd_drive_voltage,
    output logic             power_save
);
    //==========================================================
    // Pin synchronisers
    logic rst_pin_s1, rst_pin_s2;
    logic clk_in_s1, clk_in_s2;
    always_ff @(posedge ref_clk) begin
        rst_pin_s1 <= hard_reset_pin;
        rst_pin_s2 <= rst_pin_s1;
        clk_in_s1  <= ext_clock_in;
        clk_in_s2  <= clk_in_s1;
    end

    //==========================================================
    // APB decode
    wire        wr_en   = psel && penable && pwrite;
    wire        rd_en   = psel && penable && !pwrite;
    wire        hit_cmd = (paddr == `LPS_OFF_CMD);
    wire        hit_st  = (paddr == `LPS_OFF_STATUS);
    wire        hit_vol = (paddr == `LPS_OFF_CONTRAST);
    wire        hit_md  = (paddr == `LPS_OFF_MODE);
    wire        mapped  = hit_cmd | hit_st | hit_vol | hit_md;
    // Command port stays live in power save; no oscillator needed
    wire        cmd_wr  = wr_en && hit_cmd;
    wire [7:0]  cmd     = pwdata[7:0];
    wire        soft_rst = reset || rst_pin_s2;

    //==========================================================
    // Command decode
    wire c_disp_off = cmd_wr && cmd == `LPS_CMD_DISP_OFF;
    wire c_disp_on  = cmd_wr && cmd == `LPS_CMD_DISP_ON;
    wire c_all_on   = cmd_wr && cmd == `LPS_CMD_ALL_ON;
    wire c_all_off  = cmd_wr && cmd == `LPS_CMD_ALL_OFF;
    wire c_norm     = cmd_wr && cmd == `LPS_CMD_NORM;
    wire c_inv      = cmd_wr && cmd == `LPS_CMD_INV;
    wire c_dx_clr   = cmd_wr && cmd == `LPS_CMD_DUTYX_CLR;
    wire c_dx_set   = cmd_wr && cmd == `LPS_CMD_DUTYX_SET;
    wire c_sup_on   = cmd_wr && cmd == `LPS_CMD_SUPPLY_ON;
    wire c_sup_off  = cmd_wr && cmd == `LPS_CMD_SUPPLY_OFF;
    wire c_sup_end  = cmd_wr && cmd == `LPS_CMD_SUPPLY_END;
    wire c_ost      = cmd_wr && cmd[7:4] == `LPS_OST_TAG;
    // Bit 5 clear keeps the 1010 display commands out of contrast
    wire c_vol      = cmd_wr && cmd[7:6] == `LPS_VOL_TAG && !cmd[5];
    wire c_vol_reg  = wr_en && hit_vol;

    //==========================================================
    // Mode state
    logic                 save;
    logic                 disp_on;
    logic                 all_on;
    logic                 inv;
    logic                 dutyx;
    logic [3:0]           ost;
    logic [4:0]           contrast;
    lps_pkg::lps_supply_t sup;
    logic                 ext_clk_sel;

    // Power save entry is only the all-on command with display off
    wire enter_save = c_all_on && !disp_on;
    wire leave_save = save && (c_disp_on || c_all_off);

    // Mode bits are untouched by save entry and exit
    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            disp_on <= 1'b0;
            all_on  <= 1'b0;
            inv     <= 1'b0;
            dutyx   <= 1'b0;
            ost     <= `LPS_RST_OST;
        end else begin
            if (c_disp_on)  disp_on <= 1'b1;
            if (c_disp_off) disp_on <= 1'b0;
            if (c_all_on)   all_on  <= 1'b1;
            if (c_all_off)  all_on  <= 1'b0;
            if (c_norm)     inv     <= 1'b0;
            if (c_inv)      inv     <= 1'b1;
            if (c_dx_set)   dutyx   <= 1'b1;
            if (c_dx_clr)   dutyx   <= 1'b0;
            if (c_ost)      ost     <= cmd[3:0];
        end
    end

    // Contrast level from command or register
    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            contrast <= `LPS_RST_CONTRAST;
        end else if (c_vol) begin
            contrast <= cmd[4:0];
        end else if (c_vol_reg) begin
            contrast <= pwdata[4:0];
        end
    end

    // Clock source select; software choice, held over save
    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            ext_clk_sel <= 1'b0;
        end else if (wr_en && hit_md) begin
            ext_clk_sel <= pwdata[0];
        end
    end

    // Save flag; hard reset pin not expected while in save
    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            save <= 1'b0;
        end else if (enter_save) begin
            save <= 1'b1;
        end else if (leave_save) begin
            save <= 1'b0;
        end
    end

    //==========================================================
    // Built-in supply: on, wait, complete
    // Other commands and RAM stay free during the wait
    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            sup <= lps_pkg::LPS_SUP_OFF;
        end else begin
            case (sup)
                lps_pkg::LPS_SUP_OFF: begin
                    if (c_sup_on && !save) sup <= lps_pkg::LPS_SUP_WAIT;
                end
                lps_pkg::LPS_SUP_WAIT: begin
                    if (c_sup_end) sup <= lps_pkg::LPS_SUP_ON;
                    else if (c_sup_off) sup <= lps_pkg::LPS_SUP_OFF;
                end
                lps_pkg::LPS_SUP_ON: begin
                    if (c_sup_off) sup <= lps_pkg::LPS_SUP_OFF;
                end
                default: sup <= lps_pkg::LPS_SUP_OFF;
            endcase
        end
    end
    // Waiting state does not gate the command decoder
    wire sup_wait = (sup == lps_pkg::LPS_SUP_WAIT);

    //==========================================================
    // Analog and pin outputs
    logic next_osc_o;
    assign next_osc_o = ext_clk_sel ? clk_in_s2 : 1'b0;
    always_ff @(posedge ref_clk) begin
        if (soft_rst) begin
            osc_enable               <= 1'b0;
            supply_enable            <= 1'b0;
            supply_static_current    <= 1'b0;
            driver_enable            <= 1'b0;
            outputs_to_vdd           <= 1'b1;
            all_points_lit           <= 1'b0;
            display_inverse          <= 1'b0;
            lcd_drive_voltage        <= `LPS_RST_CONTRAST;
            power_save               <= 1'b0;
            oscillator_output_pin_o  <= 1'b0;
            oscillator_output_pin_oe <= 1'b0;
        end else begin
            osc_enable               <= !save;
            supply_enable            <= !save && sup != lps_pkg::LPS_SUP_OFF;
            supply_static_current    <= !save && sup_wait;
            driver_enable            <= !save && disp_on;
            outputs_to_vdd           <= save || !disp_on;
            all_points_lit           <= all_on && !save;
            display_inverse          <= inv;
            lcd_drive_voltage        <= contrast;
            power_save               <= save;
            // External clock ignored and pin floated in save
            oscillator_output_pin_o  <= save ? 1'b0 : next_osc_o;
            oscillator_output_pin_oe <= !save;
        end
    end

    //==========================================================
    // APB read data and answer
    wire [31:0] status_word = {24'h000000, inv, dutyx, !save, sup_wait,
                               sup == lps_pkg::LPS_SUP_ON, all_on, disp_on, save};
    wire [31:0] rd_mux = hit_st  ? status_word :
                         hit_vol ? {27'h0000000, contrast} :
                         hit_md  ? {27'h0000000, ost, ext_clk_sel} :
                         32'h00000000;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end else if (rd_en) begin
            prdata <= prdata;
        end
    end
endmodule

/* File: verification/lps_seq_props.sv */
`timescale 1ns/1ps
// ========
// Port checks for the power-save sequencer
module lps_seq_props (
    // Clock, reset and bus
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Power controls
    input wire logic        osc_enable,
    input wire logic        supply_enable,
    input wire logic        supply_static_current,
    input wire logic        driver_enable,
    input wire logic        outputs_to_vdd,
    input wire logic        oscillator_output_pin_oe,
    input wire logic [4:0]  lcd_drive_voltage,
    input wire logic        power_save
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Command write taken at this edge
    wire        cmd_wr = psel && penable && pwrite && paddr == 12'h000;
    wire  [7:0] cmd    = pwdata[7:0];
    // Outputs come from registered state: effects show two edges on
    sequence wr_code(logic [7:0] c);
        cmd_wr && cmd == c;
    endsequence
    a_save_entry: assert property ($rose(power_save) |->
        $past(cmd_wr, 2) && $past(cmd, 2) == 8'hA5)
        else $error("save entered without all-on command");
    a_save_osc: assert property (power_save |-> !osc_enable && !supply_enable)
        else $error("oscillator or supply running in save");
    a_save_vdd: assert property (power_save |-> outputs_to_vdd && !driver_enable)
        else $error("driver active in save");
    a_save_float: assert property (power_save |-> !oscillator_output_pin_oe)
        else $error("oscillator pin driven in save");
    a_save_exit: assert property (power_save ##0
        (wr_code(8'hAF) or wr_code(8'hA4)) |=> ##1 !power_save)
        else $error("save not left on cancel command");
    a_vol_load: assert property (cmd_wr && cmd[7:5] == 3'b100 |-> ##2
        lcd_drive_voltage == $past(cmd[4:0], 2))
        else $error("contrast level not loaded");
    a_sup_wait: assert property (!power_save && !supply_enable &&
        cmd_wr && cmd == 8'h25 |-> ##2 supply_static_current)
        else $error("supply wait not started");
    a_sup_done: assert property (cmd_wr && cmd == 8'hED |-> ##2 !supply_static_current)
        else $error("supply wait not ended");
    a_bad_addr: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
        else $error("unmapped access not refused");
endmodule

bind lps_sequencer lps_seq_props chk_u (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pslverr, .osc_enable, .supply_enable, .supply_static_current, .driver_enable,
    .outputs_to_vdd, .oscillator_output_pin_oe, .lcd_drive_voltage, .power_save);

/* File: verification/lps_host.sv */
`timescale 1ns/1ps
// ========
// Host processor model issuing commands on the register bus
module lps_host (
    // Clock
    input  wire logic        ref_clk,
    // Bus to the sequencer
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Raised when the slave never answers
    output logic             hang
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        hang = 1'b0;
    end
    // One transfer; request held until pready is seen at an edge
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        hang <= (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One command byte to the command port
    task cmd(input logic [7:0] c);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, 12'h000, {24'h0, c}, q, e);
    endtask
    // Entry order; duty-extend clear left out when the extra common is unused
    task save_seq(input logic use_dutyx);
        cmd(8'hAE);
        cmd(8'hCF);
        if (use_dutyx) cmd(8'hAA);
        cmd(8'hA5);
    endtask
    // Clearing order: display-on only after all-off, never plain power-on
    task clear_seq;
        cmd(8'hA4);
        cmd(8'hAF);
    endtask
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
// ========
// Bench for the power-save sequencer
module tb_top;
    logic        ref_clk, reset, hard_reset_pin, ext_clock_in, e;
    logic [31:0] q;
    wire         psel, penable, pwrite, pready, pslverr, hang, power_save;
    wire         osc_enable, supply_enable, supply_static_current, driver_enable;
    wire         outputs_to_vdd, all_points_lit, display_inverse, oscillator_output_pin_oe;
    wire         osc_pin;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    wire  [4:0]  lcd_drive_voltage;
    int          miscompares = 0;
    int          check_count = 0;
    lps_sequencer dut_u (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hard_reset_pin, .ext_clock_in,
        .oscillator_output_pin_o(osc_pin), .oscillator_output_pin_oe, .osc_enable, .supply_enable,
        .supply_static_current, .driver_enable, .outputs_to_vdd, .all_points_lit,
        .display_inverse, .lcd_drive_voltage, .power_save);
    lps_host host_u (.ref_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .hang);
    // ========
    // Clock, checks and verdict
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task ck(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Command, then let its output updates land
    task c(input logic [7:0] v);
        host_u.cmd(v);
        // State takes one edge, the output flops a second
        repeat (2) @(negedge ref_clk);
    endtask
    // A dead bus ends the run as a failure
    always @(posedge ref_clk) begin
        if (hang === 1'b1) begin
            miscompares++;
            print_verdict;
        end
    end
    // ========
    // Test sequence
    initial begin
        reset = 1'b1;
        hard_reset_pin = 1'b0;
        ext_clock_in = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        c(8'h9F);
        ck(lcd_drive_voltage, 5'h1F, "contrast max");
        c(8'h80);
        ck(lcd_drive_voltage, 5'h00, "contrast zero");
        host_u.xfer(1'b1, 12'h008, 32'h15, q, e);
        host_u.xfer(1'b0, 12'h008, 32'h0, q, e);
        ck(q, 32'h15, "contrast reg");
        $display("test contrast done");
        c(8'h25);
        ck(supply_static_current, 1'b1, "supply waiting");
        c(8'hA7);
        ck(display_inverse, 1'b1, "inverse in wait");
        c(8'hED);
        ck(supply_static_current, 1'b0, "supply done");
        c(8'hAF);
        c(8'hA5);
        ck(all_points_lit, 1'b1, "all lit");
        ck(power_save, 1'b0, "no save when on");
        c(8'hA4);
        ck(all_points_lit, 1'b0, "normal display");
        $display("test supply done");
        host_u.xfer(1'b1, 12'h00C, 32'h1, q, e);
        ext_clock_in <= 1'b1;
        repeat (4) @(negedge ref_clk);
        ck(osc_pin, 1'b1, "ext clock echoed");
        c(8'h24);
        host_u.save_seq(1'b1);
        repeat (2) @(negedge ref_clk);
        ck(power_save, 1'b1, "save entered");
        ck({osc_enable, supply_enable}, 2'b00, "osc supply off");
        ck({driver_enable, outputs_to_vdd}, 2'b01, "outputs high");
        ck(oscillator_output_pin_oe, 1'b0, "osc pin floats");
        ck(display_inverse, 1'b1, "mode kept");
        ck(lcd_drive_voltage, 5'h15, "contrast kept");
        ck(osc_pin, 1'b0, "ext clock ignored");
        host_u.xfer(1'b0, 12'h004, 32'h0, q, e);
        ck(q, 32'h85, "status in save");
        host_u.xfer(1'b0, 12'h00C, 32'h0, q, e);
        ck(q, 32'h1F, "output status kept");
        c(8'h25);
        ck(supply_static_current, 1'b0, "supply on refused");
        c(8'hA4);
        ck(power_save, 1'b0, "left by all-off");
        ck(display_inverse, 1'b1, "mode kept after");
        ck(supply_static_current, 1'b0, "no late supply start");
        host_u.save_seq(1'b0);
        repeat (2) @(negedge ref_clk);
        ck(power_save, 1'b1, "save without duty clear");
        host_u.clear_seq;
        repeat (2) @(negedge ref_clk);
        ck(power_save, 1'b0, "save cleared");
        $display("test save done");
        host_u.xfer(1'b0, 12'h010, 32'h0, q, e);
        ck({31'h0, e}, 32'h1, "unmapped refused");
        ck(q, 32'h0, "unmapped reads zero");
        // Refresh only between sequences, never inside one
        c(8'h95);
        ck(lcd_drive_voltage, 5'h15, "contrast refreshed");
        // Hard reset only outside power save
        c(8'h9F);
        @(posedge ref_clk);
        hard_reset_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hard_reset_pin <= 1'b0;
        repeat (4) @(negedge ref_clk);
        ck({lcd_drive_voltage, display_inverse}, 6'h00, "hard reset");
        $display("test bus and pin done");
        print_verdict;
    end
endmodule
